// >>> core/pwmfc_top.sv
// Fault handler, fault detection and capture unit for PWM operator two
// Function
// - one-shot applies direction-chosen two-bit actions
// - cycle-by-cycle uses separate up/down actions
// - per-fault one-shot source enables
// - per-fault cycle-by-cycle source enables
// - software one-shot needs its enable
// - software cycle-by-cycle needs its enable
// - any change of force bit fires one-shot
// - any change of force bit fires cycle-by-cycle
// - cycle-by-cycle refresh at zero and/or period
// - clear toggle ends one-shot action
// - one-shot active flag tracks action
// - cycle-by-cycle active flag tracks action
// - per-fault event flags follow events
// - fault event when enabled and polarity matches
// - soft sync loads capture timer from phase
// - sync source code selects sync input
// - capture timer counts each clock when enabled
// - 32-bit phase register reset to zero
// - write one forces a capture
// - invert bit inverts capture input
// - prescale rising edges by field plus one
// - mode bits pick falling/rising capture edges
// - capture stores timer value per channel
// - edge status: zero rising, one falling
//
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
module pwmfc_top
   import pwmfc_pkg::*;
#(
   parameter int PRE_W = 8
)
(
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire pwmfc_pkg::pwmfc_apb_req_t   apb_req,
   output logic [31:0]                      prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic [2:0]                  fault_input_pin,
   input  wire pwmfc_pkg::pwmfc_timer_evt_t timer_evt,
   input  wire logic                        operator_in_a,
   input  wire logic                        operator_in_b,
   input  wire logic [2:0]                  timer_sync_out,
   input  wire logic [2:0]                  external_sync_input,
   input  wire logic [1:0]                  capture_input,
   output logic                             operator_out_a,
   output logic                             operator_out_b
);
   import pwmfc_pkg::*;

   // ----------------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------------
   logic [31:0]           action_cfg_ff;
   logic [FRC_W-1:0]      force_cfg_ff;
   logic [5:0]            detect_cfg_ff;
   logic [4:0]            timer_cfg_ff;
   logic [31:0]           phase_ff;
   logic [11:0]           chan_cfg_ff [NUM_CHAN];
   logic [31:0]           cap_value_ff [NUM_CHAN];
   logic [NUM_CHAN-1:0]   cap_edge_ff;
   logic [NUM_FAULT-1:0]  fault_event_ff;
   logic                  ost_active_ff;
   logic                  cbc_active_ff;
   logic [31:0]           cap_timer_ff;
   logic                  soft_sync_ff;
   logic [NUM_CHAN-1:0]   soft_cap_ff;
   pwmfc_apb_st_t         apb_st_ff;

   logic        wr_en;
   logic        rd_en;
   logic [31:0] nxt_prdata;
   logic        addr_hit;

   // ----------------------------------------------------------------------
   // APB slave: one wait state, reads answer from a flop
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         apb_st_ff <= PWMFC_IDLE;
      else if (apb_req.psel && !apb_req.penable)
         apb_st_ff <= PWMFC_SETUP;
      else if (apb_st_ff == PWMFC_SETUP)
         apb_st_ff <= PWMFC_ACCESS;
      else
         apb_st_ff <= PWMFC_IDLE;
   end

   // Writes take effect at the edge where pready is seen high; reads load prdata one edge earlier
   assign wr_en = pready && apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign rd_en = (apb_st_ff == PWMFC_SETUP) && !apb_req.pwrite;

   always_comb
   begin
      nxt_prdata = RST_ZERO;
      addr_hit   = 1'b1;
      unique case (apb_req.paddr)
         ADDR_FAULT_ACTION_CONFIG:  nxt_prdata = action_cfg_ff;
         ADDR_FAULT_FORCE_REFRESH:  nxt_prdata[FRC_W-1:0] = force_cfg_ff;
         ADDR_FAULT_ACTION_STATE:   nxt_prdata[1:0] = {cbc_active_ff, ost_active_ff};
         ADDR_FAULT_INPUT_DETECT:   nxt_prdata[8:0] = {fault_event_ff, detect_cfg_ff};
         // Soft sync bit is write-only and reads as zero
         ADDR_CAPTURE_TIMER_CONFIG: nxt_prdata[4:0] = timer_cfg_ff;
         ADDR_CAPTURE_TIMER_PHASE:  nxt_prdata = phase_ff;
         ADDR_CAPTURE_CH0_CONFIG:   nxt_prdata[11:0] = chan_cfg_ff[0];
         ADDR_CAPTURE_CH1_CONFIG:   nxt_prdata[11:0] = chan_cfg_ff[1];
         ADDR_CAPTURE_CH0_VALUE:    nxt_prdata = cap_value_ff[0];
         ADDR_CAPTURE_CH1_VALUE:    nxt_prdata = cap_value_ff[1];
         ADDR_CAPTURE_STATUS:       nxt_prdata[NUM_CHAN-1:0] = cap_edge_ff;
         default:                   addr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= RST_ZERO;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= (apb_st_ff == PWMFC_SETUP);
         pslverr <= (apb_st_ff == PWMFC_SETUP) && !addr_hit;
         if (rd_en)
            prdata <= nxt_prdata;
      end
   end

   // ----------------------------------------------------------------------
   // Writable configuration
   // ----------------------------------------------------------------------
   // action, force, detect, timer config and phase register writes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         action_cfg_ff <= RST_ZERO;
         force_cfg_ff  <= '0;
         detect_cfg_ff <= '0;
         timer_cfg_ff  <= '0;
         phase_ff      <= RST_ZERO;
      end
      else if (wr_en)
      begin
         unique case (apb_req.paddr)
            ADDR_FAULT_ACTION_CONFIG:  action_cfg_ff <=
                                          32'(apb_req.pwdata[SRC_CBC_LSB+SRC_W-1:0]);
            ADDR_FAULT_FORCE_REFRESH:  force_cfg_ff  <= apb_req.pwdata[FRC_W-1:0];
            ADDR_FAULT_INPUT_DETECT:   detect_cfg_ff <= apb_req.pwdata[5:0];
            ADDR_CAPTURE_TIMER_CONFIG: timer_cfg_ff  <= apb_req.pwdata[4:0];
            ADDR_CAPTURE_TIMER_PHASE:  phase_ff      <= apb_req.pwdata;
            default:                   ;
         endcase
      end
   end

   // Write-only strobes live one cycle
   // soft sync strobe
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         soft_sync_ff <= 1'b0;
      else
         soft_sync_ff <= wr_en && (apb_req.paddr == ADDR_CAPTURE_TIMER_CONFIG)
                         && apb_req.pwdata[CT_SOFT_BIT];
   end

   // ----------------------------------------------------------------------
   // Fault detection
   // ----------------------------------------------------------------------
   // enable and polarity
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fault_event_ff <= '0;
      else
         fault_event_ff <= detect_cfg_ff[DET_EN_LSB +: NUM_FAULT]
                           & ~(fault_input_pin ^ detect_cfg_ff[DET_POL_LSB +: NUM_FAULT]);
   end

   // ----------------------------------------------------------------------
   // Fault handler
   // ----------------------------------------------------------------------
   logic [FRC_W-1:0] force_prev_ff;
   logic             frc_ost_tgl;
   logic             frc_cbc_tgl;
   logic             clr_ost_tgl;
   logic             ost_trig;
   logic             cbc_trig;
   logic             cbc_fault_now;
   logic             refresh_hit;
   pwmfc_action_t    act_a;
   pwmfc_action_t    act_b;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         force_prev_ff <= '0;
      else
         force_prev_ff <= force_cfg_ff;
   end

   assign frc_ost_tgl = force_cfg_ff[FRC_OST_BIT] ^ force_prev_ff[FRC_OST_BIT];
   assign frc_cbc_tgl = force_cfg_ff[FRC_CBC_BIT] ^ force_prev_ff[FRC_CBC_BIT];
   assign clr_ost_tgl = force_cfg_ff[CLR_OST_BIT] ^ force_prev_ff[CLR_OST_BIT];

   assign ost_trig = |(fault_event_ff & action_cfg_ff[SRC_OST_LSB +: NUM_FAULT])
                     || (frc_ost_tgl && action_cfg_ff[SRC_OST_LSB + SRC_SW]);
   assign cbc_fault_now = |(fault_event_ff & action_cfg_ff[SRC_CBC_LSB +: NUM_FAULT]);
   assign cbc_trig = cbc_fault_now
                     || (frc_cbc_tgl && action_cfg_ff[SRC_CBC_LSB + SRC_SW]);
   assign refresh_hit = (force_cfg_ff[REFRESH_LSB] && timer_evt.zero)
                        || (force_cfg_ff[REFRESH_LSB+1] && timer_evt.period);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ost_active_ff <= 1'b0;
      else if (ost_trig)
         ost_active_ff <= 1'b1;
      else if (clr_ost_tgl)
         ost_active_ff <= 1'b0;
   end

   // holds until refresh with no fault
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cbc_active_ff <= 1'b0;
      else if (cbc_trig)
         cbc_active_ff <= 1'b1;
      else if (refresh_hit && !cbc_fault_now)
         cbc_active_ff <= 1'b0;
   end

   assign act_a = pwmfc_action_t'(action_cfg_ff[ACT_A_LSB +: 8]);
   assign act_b = pwmfc_action_t'(action_cfg_ff[ACT_B_LSB +: 8]);

   function automatic logic apply_act(input logic [1:0] act,
                                      input logic       lvl);
      logic res;
      res = lvl;
      unique case (act)
         ACT_NONE:   res = lvl;
         ACT_LOW:    res = 1'b0;
         ACT_HIGH:   res = 1'b1;
         ACT_TOGGLE: res = ~lvl;
      endcase
      return res;
   endfunction : apply_act

   logic [1:0] sel_a;
   logic [1:0] sel_b;

   // per-cycle by direction
   // One-shot takes priority because it is the harder trip
   always_comb
   begin
      sel_a = ACT_NONE;
      sel_b = ACT_NONE;
      if (ost_active_ff)
      begin
         sel_a = timer_evt.count_up ? act_a.ost_up : act_a.ost_down;
         sel_b = timer_evt.count_up ? act_b.ost_up : act_b.ost_down;
      end
      else if (cbc_active_ff)
      begin
         sel_a = timer_evt.count_up ? act_a.cbc_up : act_a.cbc_down;
         sel_b = timer_evt.count_up ? act_b.cbc_up : act_b.cbc_down;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         operator_out_a <= 1'b0;
         operator_out_b <= 1'b0;
      end
      else
      begin
         operator_out_a <= apply_act(sel_a, operator_in_a);
         operator_out_b <= apply_act(sel_b, operator_in_b);
      end
   end

   // ----------------------------------------------------------------------
   // Capture timer
   // ----------------------------------------------------------------------
   logic [2:0] sync_sel;
   logic       sync_in;

   assign sync_sel = timer_cfg_ff[CT_SEL_LSB +: 3];

   always_comb
   begin
      sync_in = 1'b0;
      if (sync_sel >= SEL_EXT0 && sync_sel <= SEL_EXT2)
         sync_in = external_sync_input[2'(sync_sel - SEL_EXT0)];
      else if (sync_sel != SEL_NONE)
         sync_in = timer_sync_out[2'(sync_sel - SEL_TIMER0)];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cap_timer_ff <= RST_ZERO;
      else if (soft_sync_ff || (timer_cfg_ff[CT_SYNC_EN_BIT] && sync_in))
         cap_timer_ff <= phase_ff;
      else if (timer_cfg_ff[CT_EN_BIT])
         cap_timer_ff <= cap_timer_ff + 32'h0000_0001;
   end

   // ----------------------------------------------------------------------
   // Capture channels
   // ----------------------------------------------------------------------
   for (genvar ch = 0; ch < NUM_CHAN; ch++)
   begin : g_chan
      logic             in_ff;
      logic             presc_ff;
      logic [PRE_W-1:0] cnt_ff;
      logic             inv_in;
      logic             rise_in;
      logic             nxt_presc;
      logic             cap_rise;
      logic             cap_fall;
      logic [1:0]       mode;

      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            chan_cfg_ff[ch] <= '0;
            soft_cap_ff[ch] <= 1'b0;
         end
         else
         begin
            soft_cap_ff[ch] <= 1'b0;
            if (wr_en && apb_req.paddr == (ch == 0 ? ADDR_CAPTURE_CH0_CONFIG
                                                   : ADDR_CAPTURE_CH1_CONFIG))
            begin
               chan_cfg_ff[ch] <= apb_req.pwdata[CH_INV_BIT:0];
               soft_cap_ff[ch] <= apb_req.pwdata[CH_SOFT_BIT];
            end
         end
      end

      assign inv_in  = capture_input[ch] ^ chan_cfg_ff[ch][CH_INV_BIT];
      assign rise_in = inv_in && !in_ff;
      assign mode    = chan_cfg_ff[ch][CH_MODE_LSB +: 2];

      always_comb
      begin
         nxt_presc = presc_ff;
         if (rise_in && cnt_ff == chan_cfg_ff[ch][CH_PRE_LSB +: PRE_W])
            nxt_presc = 1'b1;
         else if (!inv_in)
            nxt_presc = 1'b0;
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            in_ff    <= 1'b0;
            presc_ff <= 1'b0;
            cnt_ff   <= '0;
         end
         else
         begin
            in_ff    <= inv_in;
            presc_ff <= nxt_presc;
            if (rise_in)
               cnt_ff <= (cnt_ff == chan_cfg_ff[ch][CH_PRE_LSB +: PRE_W]) ? '0
                         : cnt_ff + 1'b1;
         end
      end

      assign cap_rise = chan_cfg_ff[ch][CH_EN_BIT] && mode[1] && nxt_presc && !presc_ff;
      assign cap_fall = chan_cfg_ff[ch][CH_EN_BIT] && mode[0] && !nxt_presc && presc_ff;

      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            cap_value_ff[ch] <= RST_ZERO;
            cap_edge_ff[ch]  <= 1'b0;
         end
         else if (cap_rise || cap_fall || soft_cap_ff[ch])
         begin
            cap_value_ff[ch] <= cap_timer_ff;
            cap_edge_ff[ch]  <= cap_fall;
         end
      end
   end

endmodule : pwmfc_top

// >>> shared/pwmfc_pkg.sv
// Package for the fault handler and capture block of the PWM unit
package pwmfc_pkg;
   // ----------------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------------
   localparam logic [11:0] ADDR_FAULT_ACTION_CONFIG   = 12'h0D8;
   localparam logic [11:0] ADDR_FAULT_FORCE_REFRESH   = 12'h0DC;
   localparam logic [11:0] ADDR_FAULT_ACTION_STATE    = 12'h0E0;
   localparam logic [11:0] ADDR_FAULT_INPUT_DETECT    = 12'h0E4;
   localparam logic [11:0] ADDR_CAPTURE_TIMER_CONFIG  = 12'h0E8;
   localparam logic [11:0] ADDR_CAPTURE_TIMER_PHASE   = 12'h0EC;
   localparam logic [11:0] ADDR_CAPTURE_CH0_CONFIG    = 12'h0F0;
   localparam logic [11:0] ADDR_CAPTURE_CH1_CONFIG    = 12'h0F4;
   localparam logic [11:0] ADDR_CAPTURE_CH0_VALUE     = 12'h0FC;
   localparam logic [11:0] ADDR_CAPTURE_CH1_VALUE     = 12'h100;
   localparam logic [11:0] ADDR_CAPTURE_STATUS        = 12'h108;

   // ----------------------------------------------------------------------
   // Field layouts and reset values
   // ----------------------------------------------------------------------
   localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
   // Action config: B ost_u[1:0] ost_d[3:2] cbc_u[5:4] cbc_d[7:6], A same at 8..15
   localparam int          ACT_B_LSB       = 0;
   localparam int          ACT_A_LSB       = 8;
   localparam int          SRC_OST_LSB     = 16;  // f0,f1,f2,sw
   localparam int          SRC_CBC_LSB     = 20;  // f0,f1,f2,sw
   localparam int          SRC_W           = 4;
   localparam int          SRC_SW          = 3;
   // Force and refresh
   localparam int          FRC_OST_BIT     = 0;
   localparam int          FRC_CBC_BIT     = 1;
   localparam int          REFRESH_LSB     = 2;
   localparam int          CLR_OST_BIT     = 4;
   localparam int          FRC_W           = 5;
   // Detect: en[2:0], pol[5:3], event flags[8:6]
   localparam int          DET_EN_LSB      = 0;
   localparam int          DET_POL_LSB     = 3;
   localparam int          DET_EVT_LSB     = 6;
   localparam int          NUM_FAULT       = 3;
   // Capture timer config
   localparam int          CT_EN_BIT       = 0;
   localparam int          CT_SYNC_EN_BIT  = 1;
   localparam int          CT_SEL_LSB      = 2;
   localparam int          CT_SOFT_BIT     = 5;
   // Channel config
   localparam int          CH_EN_BIT       = 0;
   localparam int          CH_MODE_LSB     = 1;
   localparam int          CH_PRE_LSB      = 3;
   localparam int          CH_INV_BIT      = 11;
   localparam int          CH_SOFT_BIT     = 12;
   localparam int          NUM_CHAN        = 2;

   // ----------------------------------------------------------------------
   // Encodings and carriers
   // ----------------------------------------------------------------------
   localparam logic [1:0] ACT_NONE   = 2'h0;
   localparam logic [1:0] ACT_LOW    = 2'h1;
   localparam logic [1:0] ACT_HIGH   = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;
   localparam logic [2:0] SEL_NONE   = 3'h0;
   localparam logic [2:0] SEL_TIMER0 = 3'h1;
   localparam logic [2:0] SEL_EXT0   = 3'h4;
   localparam logic [2:0] SEL_EXT2   = 3'h6;

   typedef enum logic [1:0] {
      PWMFC_IDLE,
      PWMFC_SETUP,
      PWMFC_ACCESS
   } pwmfc_apb_st_t;

   // Highest field first, so that a cast of bits [7:0] puts ost_up at [1:0]
   typedef struct packed {
      logic [1:0] cbc_down;
      logic [1:0] cbc_up;
      logic [1:0] ost_down;
      logic [1:0] ost_up;
   } pwmfc_action_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } pwmfc_apb_req_t;

   typedef struct packed {
      logic       zero;     // timer_equals_zero pulse
      logic       period;   // timer_equals_period pulse
      logic       count_up; // operator timer direction
   } pwmfc_timer_evt_t;
endpackage : pwmfc_pkg

// >>> verification/pwmfc_checker_assertions.sv
// Port-level checker for the fault handler and capture block
`timescale 1ns/100ps
module pwmfc_checker
   import pwmfc_pkg::*;
#(
   parameter int PRE_W = 8
)
(
   input wire logic                      pclk,
   input wire logic                      presetn,
   input wire pwmfc_pkg::pwmfc_apb_req_t apb_req,
   input wire logic [31:0]               prdata,
   input wire logic                      pready,
   input wire logic                      pslverr,
   input wire logic                      operator_in_a,
   input wire logic                      operator_in_b,
   input wire logic                      operator_out_a,
   input wire logic                      operator_out_b
);
   import pwmfc_pkg::*;
   logic [31:0] phase_ff;
   logic        src_seen_ff;
   logic [1:0]  up_ff;
   logic [11:0] adr;
   logic        wr_done;
   logic        rd_done;
   assign adr = apb_req.paddr;
   assign wr_done = apb_req.psel && apb_req.penable && pready && apb_req.pwrite;
   assign rd_done = apb_req.psel && apb_req.penable && pready && !apb_req.pwrite;
   // ------------------------------------------------------------
   // Helper state
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         phase_ff <= RST_ZERO;
      else if (wr_done && adr == ADDR_CAPTURE_TIMER_PHASE)
         phase_ff <= apb_req.pwdata;
   end
   // Until a source is enabled no action can exist, so outputs pass through
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         src_seen_ff <= 1'h0;
      else if (wr_done && adr == ADDR_FAULT_ACTION_CONFIG && apb_req.pwdata[23:16] != 8'h0)
         src_seen_ff <= 1'h1;
   end
   // Skips the edges right after release, where outputs are still held low
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         up_ff <= 2'h0;
      else if (up_ff != 2'h3)
         up_ff <= up_ff + 2'h1;
   end
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_after_setup_a: assert property (apb_req.psel && !apb_req.penable |-> ##2 pready)
      else $error("no ready after setup");
   error_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   phase_readback_a: assert property (
      rd_done && adr == ADDR_CAPTURE_TIMER_PHASE |-> prdata == phase_ff)
      else $error("phase readback differs");
   status_reserved_a: assert property (
      rd_done && adr == ADDR_FAULT_ACTION_STATE |-> prdata[31:2] == 30'h0)
      else $error("action state reserved bits set");
   detect_reserved_a: assert property (
      rd_done && adr == ADDR_FAULT_INPUT_DETECT |-> prdata[31:9] == 23'h0)
      else $error("detect reserved bits set");
   soft_sync_wo_a: assert property (
      rd_done && adr == ADDR_CAPTURE_TIMER_CONFIG |-> !prdata[CT_SOFT_BIT])
      else $error("soft sync bit reads back");
   soft_capture_wo_a: assert property (
      rd_done && (adr == ADDR_CAPTURE_CH0_CONFIG || adr == ADDR_CAPTURE_CH1_CONFIG)
      |-> !prdata[CH_SOFT_BIT]) else $error("soft capture bit reads back");
   edge_status_a: assert property (
      rd_done && adr == ADDR_CAPTURE_STATUS |-> prdata[31:2] == 30'h0)
      else $error("edge status reserved bits set");
   normal_path_a: assert property (
      up_ff == 2'h3 && !src_seen_ff |-> operator_out_a == $past(operator_in_a)
      && operator_out_b == $past(operator_in_b)) else $error("outputs forced without source");
endmodule : pwmfc_checker

// >>> verification/pwmfc_far.sv
// Far-side model: fault pins, capture pins and operator timer events
`timescale 1ns/100ps
module pwmfc_far
   import pwmfc_pkg::*;
(
   input  wire logic                 pclk,
   output pwmfc_pkg::pwmfc_timer_evt_t evt,
   output logic [2:0]                fault,
   output logic [1:0]                cap
);
   import pwmfc_pkg::*;
   logic [2:0] ph;
   initial
   begin
      evt = '0;
      fault = 3'h0;
      cap = 2'h0;
      ph = 3'h0;
   end
   // Operator timer: zero every eight cycles, period halfway
   always @(posedge pclk)
   begin
      ph <= ph + 3'h1;
      evt.zero <= (ph == 3'h7);
      evt.period <= (ph == 3'h3);
   end
   task lvl(input logic [2:0] f, input logic [1:0] c, input logic up);
      @(posedge pclk);
      fault <= f;
      cap <= c;
      evt.count_up <= up;
   endtask : lvl
endmodule : pwmfc_far

// >>> verification/tb_pwmfc_top.sv
// Self-checking bench for the fault handler and capture block
`timescale 1ns/100ps
module tb_pwmfc_top;
   import pwmfc_pkg::*;
   logic             pclk;
   logic             presetn;
   pwmfc_apb_req_t   req;
   pwmfc_timer_evt_t evt;
   logic [31:0]      prdata;
   logic [31:0]      rd;
   logic [31:0]      vs;
   logic [2:0]       fault;
   logic [1:0]       cap;
   logic [5:0]       syncs;
   logic             pready, pslverr, err, in_a, in_b, out_a, out_b;
   int               mismatches, samples_checked, cyc, ts, ws;
   pwmfc_far far (.pclk(pclk), .evt(evt), .fault(fault), .cap(cap));
   pwmfc_top #(.PRE_W(8)) uut (.pclk(pclk), .presetn(presetn), .apb_req(req),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .fault_input_pin(fault),
      .timer_evt(evt), .operator_in_a(in_a), .operator_in_b(in_b),
      .timer_sync_out(syncs[2:0]), .external_sync_input(syncs[5:3]), .capture_input(cap),
      .operator_out_a(out_a), .operator_out_b(out_b));
   initial
   begin
      pclk = 1'h0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         mismatches++;
         print_verdict;
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      req <= '{1'h1, 1'h0, w, a, d};
      @(posedge pclk);
      req.penable <= 1'h1;
      // Only the cycle timeout ends a wait for the slave
      do
         @(posedge pclk);
      while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      ts = cyc;
      req.psel <= 1'h0;
      req.penable <= 1'h0;
   endtask : xfer
   task rchk(input logic [11:0] a, input logic [31:0] e);
      xfer(a, 1'h0, 32'h0);
      chk(rd, e);
   endtask : rchk
   task print_verdict;
      $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   initial
   begin
      {presetn, in_a, in_b, syncs, mismatches, samples_checked, cyc} = '0;
      req = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      rchk(ADDR_FAULT_ACTION_CONFIG, 32'h0);
      rchk(ADDR_CAPTURE_TIMER_PHASE, 32'h0);
      xfer(ADDR_CAPTURE_TIMER_PHASE, 1'h1, 32'hA5A5_5A5A);
      rchk(ADDR_CAPTURE_TIMER_PHASE, 32'hA5A5_5A5A);
      rchk(12'h0C0, 32'h0);
      chk({31'h0, err}, 32'h1);
      // Sync loads the phase, then the timer counts one per clock
      xfer(ADDR_CAPTURE_TIMER_CONFIG, 1'h1, 32'h21);
      ws = ts;
      xfer(ADDR_CAPTURE_CH0_CONFIG, 1'h1, 32'h1000);
      // Capture takes the timer as it stood one edge before the strobe acts
      vs = 32'hA5A5_5A5A + 32'(ts - ws - 1);
      rchk(ADDR_CAPTURE_CH0_VALUE, vs);
      rchk(ADDR_CAPTURE_STATUS, 32'h0);
      // Divide by two on rising edges: first pulse must not capture
      xfer(ADDR_CAPTURE_CH0_CONFIG, 1'h1, 32'hD);
      far.lvl(3'h0, 2'h1, 1'h1);
      far.lvl(3'h0, 2'h0, 1'h1);
      rchk(ADDR_CAPTURE_CH0_VALUE, vs);
      far.lvl(3'h0, 2'h1, 1'h1);
      far.lvl(3'h0, 2'h0, 1'h1);
      xfer(ADDR_CAPTURE_CH0_VALUE, 1'h0, 32'h0);
      chk({31'h0, rd != vs}, 32'h1);
      xfer(ADDR_CAPTURE_CH1_CONFIG, 1'h1, 32'h3);
      far.lvl(3'h0, 2'h2, 1'h1);
      far.lvl(3'h0, 2'h0, 1'h1);
      rchk(ADDR_CAPTURE_STATUS, 32'h2);
      // One-shot from a high-level fault on input 0
      in_b <= 1'h1;
      xfer(ADDR_FAULT_INPUT_DETECT, 1'h1, 32'h9);
      far.lvl(3'h1, 2'h0, 1'h1);
      rchk(ADDR_FAULT_INPUT_DETECT, 32'h49);
      xfer(ADDR_FAULT_ACTION_CONFIG, 1'h1, 32'h0001_0201);
      repeat (4) @(posedge pclk);
      chk({30'h0, out_a, out_b}, 32'h2);
      rchk(ADDR_FAULT_ACTION_STATE, 32'h1);
      far.lvl(3'h0, 2'h0, 1'h0);
      xfer(ADDR_FAULT_FORCE_REFRESH, 1'h1, 32'h10);
      repeat (3) @(posedge pclk);
      rchk(ADDR_FAULT_ACTION_STATE, 32'h0);
      chk({30'h0, out_a, out_b}, 32'h1);
      // Software cycle-by-cycle while counting down
      xfer(ADDR_FAULT_ACTION_CONFIG, 1'h1, 32'h0080_8040);
      xfer(ADDR_FAULT_FORCE_REFRESH, 1'h1, 32'h12);
      repeat (3) @(posedge pclk);
      chk({30'h0, out_a, out_b}, 32'h2);
      repeat (20) @(posedge pclk);
      rchk(ADDR_FAULT_ACTION_STATE, 32'h2);
      xfer(ADDR_FAULT_FORCE_REFRESH, 1'h1, 32'h16);
      repeat (12) @(posedge pclk);
      rchk(ADDR_FAULT_ACTION_STATE, 32'h0);
      chk({30'h0, out_a, out_b}, 32'h1);
      // Held timer loads the phase from the chosen sync input
      xfer(ADDR_CAPTURE_TIMER_CONFIG, 1'h1, 32'h12);
      xfer(ADDR_CAPTURE_TIMER_PHASE, 1'h1, 32'h1234);
      syncs <= 6'h08;
      @(posedge pclk);
      syncs <= 6'h00;
      // Inverted idle-low pin looks like a rising edge
      xfer(ADDR_CAPTURE_CH1_CONFIG, 1'h1, 32'h805);
      rchk(ADDR_CAPTURE_CH1_VALUE, 32'h1234);
      rchk(ADDR_CAPTURE_STATUS, 32'h0);
      xfer(ADDR_CAPTURE_TIMER_CONFIG, 1'h1, 32'h6);
      xfer(ADDR_CAPTURE_TIMER_PHASE, 1'h1, 32'h5678);
      syncs <= 6'h01;
      @(posedge pclk);
      syncs <= 6'h00;
      xfer(ADDR_CAPTURE_CH0_CONFIG, 1'h1, 32'h100D);
      rchk(ADDR_CAPTURE_CH0_VALUE, 32'h5678);
      print_verdict;
   end
endmodule : tb_pwmfc_top
bind pwmfc_top pwmfc_checker #(.PRE_W(PRE_W)) chk (.pclk(pclk), .presetn(presetn),
   .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .operator_in_a(operator_in_a), .operator_in_b(operator_in_b),
   .operator_out_a(operator_out_a), .operator_out_b(operator_out_b));
